// file: rtl/eeprom_consts.svh
// Purpose: named constants of the serial EEPROM command, status and protection block
// Assumes: 10 MHz system clock
// Notes:   definitions only
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH

// ==========================================================
// opcodes, compared after masking the don't-care bit 3
`define OP_MASK          8'hF7
`define OP_LATCH_SET     8'h06
`define OP_LATCH_CLEAR   8'h04
`define OP_STATUS_READ   8'h05
`define OP_STATUS_WRITE  8'h01
`define OP_ARRAY_READ    8'h03
`define OP_ARRAY_WRITE   8'h02

// ==========================================================
// status register field positions
`define ST_PEN_BIT       7
`define ST_BPHI_BIT      3
`define ST_BPLO_BIT      2
`define ST_RSV_ON        3'h7
`define ST_RSV_OFF       3'h0

// ==========================================================
// block protection: start of the read-only range per level
`define BP_NONE          2'h0
`define BP_QUARTER       2'h1
`define BP_HALF          2'h2
`define BP_ALL           2'h3
`define BP_QUARTER_BASE  17'h18000
`define BP_HALF_BASE     17'h10000

// ==========================================================
// framing and timing
`define BIT_LAST         3'h7
`define ADDR_BYTES       2'h3
`define CLK_PERIOD_NS    100
`define WRITE_TIME_NS    5000000

`endif

// file: rtl/eeprom_pkg.sv
// Purpose: types shared by the serial EEPROM command, status and protection block
// Assumes: constants come from eeprom_consts.svh
// Notes:   types only
package eeprom_pkg;

  // ==========================================================
  // status register as it reads on the serial output
  typedef struct packed {
    logic       pinProtectEnable;
    logic [2:0] reservedBits;
    logic       blockProtectHi;
    logic       blockProtectLo;
    logic       writeEnableLatch;
    logic       busyFlag;
  } status_t;

  // nonvolatile part of the status register
  typedef struct packed {
    logic pinProtectEnable;
    logic blockProtectHi;
    logic blockProtectLo;
  } nv_t;

  // serial pins as they enter the block
  typedef struct packed {
    logic csN;
    logic sck;
    logic si;
    logic wpN;
  } pins_t;

  // ==========================================================
  // frame phase
  typedef enum logic [2:0] {
    PH_IDLE      = 3'b000,
    PH_OPCODE    = 3'b001,
    PH_CMD_DONE  = 3'b010,
    PH_STAT_OUT  = 3'b011,
    PH_STAT_DATA = 3'b100,
    PH_STAT_DONE = 3'b101,
    PH_ARRAY     = 3'b110,
    PH_IGNORE    = 3'b111
  } phase_t;

  // kind of internal write cycle in progress
  typedef enum logic [1:0] {
    WR_NONE   = 2'b00,
    WR_STATUS = 2'b01,
    WR_ARRAY  = 2'b10
  } write_kind_t;

endpackage

// file: rtl/pin_sync.sv
// Purpose: two-stage synchroniser for pins that arrive from outside the clock domain
// Assumes: clkEn low freezes both stages
// Notes:   only the second stage is visible; the first feeds nothing else
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] pinIn,
  input  wire logic [WIDTH-1:0] resetLevel,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] metaQ;

  // ==========================================================
  // per-bit chains; idle level chosen per pin so reset looks like a deselected bus
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        metaQ[i]  <= 1'b0;
        pinOut[i] <= 1'b0;
      end else if (clkEn) begin
        metaQ[i]  <= pinIn[i] ^ resetLevel[i];
        pinOut[i] <= metaQ[i];
      end
    end
  end

endmodule

// file: rtl/spi_eeprom_cmd_status_protect.sv
// Purpose: opcode decoder, status register and write protection of a serial EEPROM (SPI slave)
// Assumes: SPI pins are sampled by clk (10 MHz), so the serial clock must be well below clk/4
// Notes:   array data path, hold and page addressing sit outside; array writes are granted here
//
// Behaviour
// - falling chip select starts a frame; first eight bits, MSB first, form the opcode.
// - status opcodes decode with bit 3 ignored: 06 set, 04 clear, 05 read, 01 write.
// - array opcodes decode with bit 3 ignored: 03 read, 02 write.
// - status is eight bits: enable 7, reserved 6:4, protect 3:2, latch 1, busy 0.
// - reserved bits read zero when idle, ones during an internal write.
// - busy flag is one during an internal operation; software cannot write it.
// - opcode 05 shifts the status byte out MSB first right after the opcode.
// - after opcode 06, the latch sets when chip select rises.
// - status and array writes act only while the latch is one.
// - the latch is zero after power-up.
// - opcode 04 clears the latch regardless of the protect pin.
// - status write changes only bits 7, 3 and 2.
// - protect enable and block bits are nonvolatile.
// - valid status write starts a timed write; meanwhile only status read is obeyed.
// - the latch clears when an internal write cycle completes.
// - block bits protect none, 18000h up, 10000h up, or the whole array.
// - pin low with protect enable set refuses every status write.
// - pin high or protect enable clear allows status writes when the latch is set.
// - protected locations never written; others only with the latch set.
// - unknown opcode: no more data taken, output stays off until next frame.
// - pin going low mid-frame with protect enable set aborts a pending status write; started cycles continue.
// - input sampled on rising serial clock, output changed on falling; modes 0 and 3.
`include "eeprom_consts.svh"

module spi_eeprom_cmd_status_protect #(
  parameter int WriteTimeNs = `WRITE_TIME_NS
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 clkEn,
  input  wire logic                 chipSelN,
  input  wire logic                 serialClk,
  input  wire logic                 serialIn,
  input  wire logic                 writeProtectN,
  input  wire eeprom_pkg::nv_t      nvPowerUp,
  output logic                      serialOut,
  output logic                      serialOutEn,
  output eeprom_pkg::status_t       status,
  output eeprom_pkg::nv_t           nvStore,
  output logic                      arrayWriteGo,
  output logic               [16:0] arrayWriteAddr
);
  import eeprom_pkg::*;

  localparam int WriteCyclesRaw = WriteTimeNs / `CLK_PERIOD_NS;
  localparam int WriteCycles    = (WriteCyclesRaw < 1) ? 1 : WriteCyclesRaw;

  // ==========================================================
  // pin synchronisation and edge detection
  pins_t pinsRaw;
  pins_t pinsSync;
  pins_t pinsPrevQ;
  pins_t pinsIdle;
  logic  csFall;
  logic  csRise;
  logic  sckRise;
  logic  sckFall;
  logic  selected;

  assign pinsRaw  = '{csN: chipSelN, sck: serialClk, si: serialIn, wpN: writeProtectN};
  // chip select and protect pin reset as high so no frame is seen at release
  assign pinsIdle = '{csN: 1'b1, sck: 1'b0, si: 1'b0, wpN: 1'b1};

  pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk        (clk),
    .rstn       (rstn),
    .clkEn      (clkEn),
    .pinIn      (pinsRaw),
    .resetLevel (pinsIdle),
    .pinOut     (pinsSync)
  );

  pins_t pinsNow;
  assign pinsNow = pinsSync ^ pinsIdle;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinsPrevQ <= '{csN: 1'b1, sck: 1'b0, si: 1'b0, wpN: 1'b1};
    end else if (clkEn) begin
      pinsPrevQ <= pinsNow;
    end
  end

  assign csFall   = pinsPrevQ.csN & ~pinsNow.csN;
  assign csRise   = ~pinsPrevQ.csN & pinsNow.csN;
  assign selected = ~pinsNow.csN & ~pinsPrevQ.csN;
  assign sckRise  = selected & ~pinsPrevQ.sck & pinsNow.sck;
  assign sckFall  = selected & pinsPrevQ.sck & ~pinsNow.sck;

  // ==========================================================
  // status register state
  logic        latchQ;
  logic        busyQ;
  write_kind_t kindQ;
  nv_t         nvQ;
  nv_t         nvPendQ;
  logic        nvLoadedQ;
  logic [31:0] busyCntQ;
  logic        writeDone;
  status_t     statusNow;
  logic        hwProtect;

  assign hwProtect = ~pinsNow.wpN & nvQ.pinProtectEnable;

  always_comb begin
    statusNow.pinProtectEnable = nvQ.pinProtectEnable;
    statusNow.reservedBits     = busyQ ? `ST_RSV_ON : `ST_RSV_OFF;
    statusNow.blockProtectHi   = nvQ.blockProtectHi;
    statusNow.blockProtectLo   = nvQ.blockProtectLo;
    statusNow.writeEnableLatch = latchQ;
    statusNow.busyFlag         = busyQ;
  end

  // ==========================================================
  // frame decoding
  phase_t      phaseQ;
  logic [2:0]  bitCntQ;
  logic [6:0]  shiftQ;
  logic [7:0]  opcodeQ;
  logic [7:0]  statDataQ;
  logic [1:0]  addrCntQ;
  logic [16:0] addrQ;
  logic        dataSeenQ;
  logic        abortQ;
  logic [7:0]  rxByte;
  logic [7:0]  opMasked;
  logic        byteDone;

  assign rxByte   = {shiftQ, pinsNow.si};
  assign opMasked = rxByte & `OP_MASK;
  assign byteDone = sckRise && (bitCntQ == `BIT_LAST);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phaseQ    <= PH_IDLE;
      bitCntQ   <= 3'h0;
      shiftQ    <= 7'h00;
      opcodeQ   <= 8'h00;
      statDataQ <= 8'h00;
      addrCntQ  <= 2'h0;
      addrQ     <= 17'h00000;
      dataSeenQ <= 1'b0;
    end else if (clkEn) begin
      if (csRise) begin
        phaseQ <= PH_IDLE;
      end else if (csFall) begin
        phaseQ    <= PH_OPCODE;
        bitCntQ   <= 3'h0;
        addrCntQ  <= 2'h0;
        dataSeenQ <= 1'b0;
      end else if (sckRise && phaseQ != PH_IGNORE && phaseQ != PH_IDLE) begin
        shiftQ  <= rxByte[6:0];
        bitCntQ <= bitCntQ + 3'h1;
        if (byteDone) begin
          unique case (phaseQ)
            PH_OPCODE: begin
              opcodeQ <= opMasked;
              if (busyQ && opMasked != `OP_STATUS_READ) begin
                phaseQ <= PH_IGNORE;
              end else begin
                unique case (opMasked)
                  `OP_LATCH_SET, `OP_LATCH_CLEAR: phaseQ <= PH_CMD_DONE;
                  `OP_STATUS_READ:                phaseQ <= PH_STAT_OUT;
                  `OP_STATUS_WRITE:               phaseQ <= PH_STAT_DATA;
                  `OP_ARRAY_READ, `OP_ARRAY_WRITE: phaseQ <= PH_ARRAY;
                  default:                        phaseQ <= PH_IGNORE;
                endcase
              end
            end
            PH_STAT_DATA: begin
              statDataQ <= rxByte;
              phaseQ    <= PH_STAT_DONE;
            end
            PH_ARRAY: begin
              if (addrCntQ != `ADDR_BYTES) begin
                addrQ    <= {addrQ[8:0], rxByte};
                addrCntQ <= addrCntQ + 2'h1;
              end else begin
                dataSeenQ <= 1'b1;
              end
            end
            // extra bytes after a complete short command void it
            PH_CMD_DONE, PH_STAT_DONE: phaseQ <= PH_IGNORE;
            PH_STAT_OUT:               phaseQ <= PH_STAT_OUT;
            PH_IDLE, PH_IGNORE:        phaseQ <= phaseQ;
          endcase
        end
      end
    end
  end

  // pin drop during a pending status write sticks until the next frame starts
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      abortQ <= 1'b0;
    end else if (clkEn) begin
      if (csFall) begin
        abortQ <= 1'b0;
      end else if (selected && hwProtect && (phaseQ == PH_STAT_DATA || phaseQ == PH_STAT_DONE)) begin
        abortQ <= 1'b1;
      end
    end
  end

  // ==========================================================
  // commands taken at the rising chip select
  logic onBoundary;
  logic doLatchSet;
  logic doLatchClear;
  logic doStatusWrite;
  logic doArrayWrite;
  logic addrProtected;

  always_comb begin
    unique case ({nvQ.blockProtectHi, nvQ.blockProtectLo})
      `BP_NONE:    addrProtected = 1'b0;
      `BP_QUARTER: addrProtected = (addrQ >= `BP_QUARTER_BASE);
      `BP_HALF:    addrProtected = (addrQ >= `BP_HALF_BASE);
      `BP_ALL:     addrProtected = 1'b1;
    endcase
  end

  assign onBoundary    = csRise && (bitCntQ == 3'h0);
  assign doLatchSet    = onBoundary && phaseQ == PH_CMD_DONE && opcodeQ == `OP_LATCH_SET;
  assign doLatchClear  = onBoundary && phaseQ == PH_CMD_DONE && opcodeQ == `OP_LATCH_CLEAR;
  assign doStatusWrite = onBoundary && phaseQ == PH_STAT_DONE && latchQ
                         && !hwProtect && !abortQ;
  assign doArrayWrite  = onBoundary && phaseQ == PH_ARRAY && opcodeQ == `OP_ARRAY_WRITE
                         && dataSeenQ && latchQ && !addrProtected;

  // ==========================================================
  // write enable latch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latchQ <= 1'b0;
    end else if (clkEn) begin
      if (doLatchClear || writeDone) begin
        latchQ <= 1'b0;
      end else if (doLatchSet) begin
        latchQ <= 1'b1;
      end
    end
  end

  // ==========================================================
  // self-timed internal write and nonvolatile bits
  assign writeDone = busyQ && (busyCntQ == 32'(WriteCycles - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busyQ    <= 1'b0;
      kindQ    <= WR_NONE;
      busyCntQ <= 32'h0;
      nvPendQ  <= '0;
    end else if (clkEn) begin
      if (writeDone) begin
        busyQ <= 1'b0;
        kindQ <= WR_NONE;
      end else if (busyQ) begin
        busyCntQ <= busyCntQ + 32'h1;
      end else if (doStatusWrite || doArrayWrite) begin
        busyQ    <= 1'b1;
        busyCntQ <= 32'h0;
        kindQ    <= doStatusWrite ? WR_STATUS : WR_ARRAY;
        nvPendQ  <= '{pinProtectEnable: statDataQ[`ST_PEN_BIT],
                      blockProtectHi:   statDataQ[`ST_BPHI_BIT],
                      blockProtectLo:   statDataQ[`ST_BPLO_BIT]};
      end
    end
  end

  // nonvolatile bits are restored from the outside store after reset release,
  // because an asynchronous reset may only load constants
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nvQ       <= '0;
      nvLoadedQ <= 1'b0;
    end else if (clkEn) begin
      if (!nvLoadedQ) begin
        nvQ       <= nvPowerUp;
        nvLoadedQ <= 1'b1;
      end else if (writeDone && kindQ == WR_STATUS) begin
        nvQ <= nvPendQ;
      end
    end
  end

  // ==========================================================
  // serial output
  logic [7:0] txQ;
  logic [2:0] txCntQ;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txQ         <= 8'h00;
      txCntQ      <= 3'h0;
      serialOut   <= 1'b0;
      serialOutEn <= 1'b0;
    end else if (clkEn) begin
      if (csRise || csFall) begin
        serialOutEn <= 1'b0;
        txCntQ      <= 3'h0;
      end else if (sckFall && phaseQ == PH_STAT_OUT) begin
        // status is resampled at each byte so polling sees busy drop
        serialOut   <= (txCntQ == 3'h0) ? statusNow[7] : txQ[7];
        txQ         <= (txCntQ == 3'h0) ? {statusNow[6:0], 1'b0} : {txQ[6:0], 1'b0};
        txCntQ      <= txCntQ + 3'h1;
        serialOutEn <= 1'b1;
      end
    end
  end

  // ==========================================================
  // registered status view and array write grant
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status         <= '0;
      nvStore        <= '0;
      arrayWriteGo   <= 1'b0;
      arrayWriteAddr <= 17'h00000;
    end else if (clkEn) begin
      status       <= statusNow;
      nvStore      <= nvQ;
      arrayWriteGo <= doArrayWrite;
      if (doArrayWrite) begin
        arrayWriteAddr <= addrQ;
      end
    end
  end

endmodule

// file: tb/spi_master_model.sv
// Purpose: SPI master model driving the serial EEPROM pins in mode 0
// Assumes: frame is called 1 ns after a clk rise; serial clock period 800 ns
// Notes:   the serial clock stands at its idle level between frames; mode 3 through set_mode
module spi_master_model (
  output logic      csN,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  timeunit 1ns;
  timeprecision 1ns;

  logic cpol;

  initial begin
    cpol = 1'b0;
    csN  = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // idle level of the serial clock: low for mode 0, high for mode 3
  task automatic set_mode(input logic m3);
    cpol = m3;
    sck  = m3;
    #800;
  endtask

  // ==========================================================
  // one frame of nb bytes; rx keeps the last eight bits seen on so
  task automatic frame(input int nb, input logic [39:0] tx, output logic [7:0] rx);
    rx  = 8'h00;
    csN = 1'b0;
    #400;
    for (int i = nb * 8 - 1; i >= 0; i--) begin
      sck = 1'b0;
      si  = tx[i];
      #400;
      sck = 1'b1;
      rx  = {rx[6:0], so};
      #400;
    end
    sck = cpol;
    #400;
    csN = 1'b1;
    // a released line must not keep showing its last bit
    si  = ~si;
    #800;
  endtask
endmodule

// file: tb/spi_eeprom_cmd_status_protect_properties.sv
// Purpose: port-level checks of the EEPROM command, status and protection block
// Assumes: status lags the internal state by one clk
// Notes:   bound into every instance of the block
module spi_eeprom_cmd_status_protect_properties #(
  parameter int WriteTimeNs = 5000000
) (
  input wire logic                clk,
  input wire logic                rstn,
  input wire logic                chipSelN,
  input wire logic                serialOutEn,
  input wire eeprom_pkg::status_t status,
  input wire logic                arrayWriteGo,
  input wire logic         [16:0] arrayWriteAddr
);
  import eeprom_pkg::*;
  localparam int BusyLen = WriteTimeNs / 100;
  logic [1:0] bpNow;
  assign bpNow = {status.blockProtectHi, status.blockProtectLo};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // length of the running write cycle; a counter because it is far beyond any delay range
  int busyRun;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busyRun <= 0;
    end else if (status.busyFlag) begin
      busyRun <= busyRun + 1;
    end else begin
      busyRun <= 0;
    end
  end

  // ==========================================================
  // write cycle phases
  sequence busyHold;
    status.busyFlag [*8];
  endsequence
  sequence busyEnds;
    !status.busyFlag ##0 (busyRun == BusyLen);
  endsequence

  AST_RSV_MIRRORS_BUSY: assert property (status.reservedBits == {3{status.busyFlag}})
    else $error("reserved bits disagree with busy flag");
  AST_BUSY_BOUNDED: assert property ($rose(status.busyFlag) |-> busyHold)
    else $error("write cycle shorter than minimum");
  AST_BUSY_LENGTH: assert property ($fell(status.busyFlag) |-> busyEnds)
    else $error("write cycle length differs from the timed write");
  AST_LATCH_SET_AT_CS_HIGH: assert property ($rose(status.writeEnableLatch) |-> chipSelN)
    else $error("latch set while selected");
  AST_BUSY_AT_CS_HIGH: assert property ($rose(status.busyFlag) |-> chipSelN)
    else $error("write cycle started while selected");
  AST_END_CLEARS_LATCH: assert property ($fell(status.busyFlag) |-> ##[0:1] !status.writeEnableLatch)
    else $error("latch kept after write cycle");
  AST_GO_NEEDS_LATCH: assert property (arrayWriteGo |-> status.writeEnableLatch)
    else $error("array write granted without latch");
  AST_GO_OUTSIDE_BLOCK: assert property (arrayWriteGo |-> bpNow != 2'h3
      && !(bpNow == 2'h2 && arrayWriteAddr >= 17'h10000) && !(bpNow == 2'h1 && arrayWriteAddr >= 17'h18000))
    else $error("array write granted inside protected range");
  AST_GO_PULSE_BUSY: assert property (arrayWriteGo |=> !arrayWriteGo ##[0:2] status.busyFlag)
    else $error("array write grant not followed by write cycle");
  AST_OUT_OFF_DESELECTED: assert property (chipSelN [*5] |-> !serialOutEn)
    else $error("serial output driven while deselected");
  AST_LATCH_HOLD_SELECTED: assert property ((!chipSelN && !status.busyFlag) [*5]
      |-> $stable(status.writeEnableLatch))
    else $error("latch changed inside a frame");
endmodule

bind spi_eeprom_cmd_status_protect spi_eeprom_cmd_status_protect_properties #(.WriteTimeNs(WriteTimeNs)) u_props (
  .clk(clk), .rstn(rstn), .chipSelN(chipSelN), .serialOutEn(serialOutEn), .status(status),
  .arrayWriteGo(arrayWriteGo), .arrayWriteAddr(arrayWriteAddr));

// file: tb/spi_eeprom_cmd_status_protect_tb.sv
// Purpose: self-checking bench of the EEPROM command, status and protection block
// Assumes: 10 MHz clk, 800 ns serial clock, short write time
// Notes:   integer model of latch and nonvolatile bits
module spi_eeprom_cmd_status_protect_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import eeprom_pkg::*;
  localparam int WrNs = 30000;
  logic        clk = 1'b0, rstn = 1'b0, wpN = 1'b1, so, soEn, go, csN, sck, si;
  logic [16:0] wAddr, lastAddr;
  logic [7:0]  rx, d;
  nv_t         nvIn = '0, nvOut;
  status_t     st;
  int          err_total = 0, comparisons = 0, cycles = 0, goCnt = 0, enCnt = 0;
  int          pen, bp, write_enable_latch, ok;
  int          addrs[6] = '{32'h0, 32'hFFFF, 32'h10000, 32'h17FFF, 32'h18000, 32'h1FFFF};
  logic        soLine;

  // a released output shows the inverse of its last bit, so a read of an undriven line fails
  assign soLine = soEn ? so : ~so;

  always #50 clk = ~clk;

  spi_master_model master (.csN(csN), .sck(sck), .si(si), .so(soLine));
  spi_eeprom_cmd_status_protect #(.WriteTimeNs(WrNs)) DUT (
    .clk(clk), .rstn(rstn), .clkEn(1'b1), .chipSelN(csN), .serialClk(sck), .serialIn(si),
    .writeProtectN(wpN), .nvPowerUp(nvIn), .serialOut(so), .serialOutEn(soEn), .status(st),
    .nvStore(nvOut), .arrayWriteGo(go), .arrayWriteAddr(wAddr));

  always @(posedge clk) begin
    cycles++;
    if (go === 1'b1) begin
      goCnt++;
      lastAddr = wAddr;
    end
    if (soEn === 1'b1) enCnt++;
    if (cycles > 90000) begin
      err_total++;
      finish_test();
    end
  end

  // ==========================================================
  // shared checks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] expSt(input int busy);
    return {pen[0], {3{busy[0]}}, bp[1:0], write_enable_latch[0], busy[0]};
  endfunction
  task automatic rd(input int busy);
    master.frame(2, 40'h0500, rx);
    check("status read", rx, expSt(busy));
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 400 && st.busyFlag !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    check("status", st, expSt(0));
  endtask
  task automatic wrStat(input logic [7:0] dat, input int en);
    if (en) begin
      master.frame(1, 40'h06, rx);
      write_enable_latch = 1;
    end
    master.frame(2, {24'h0, 8'h01, dat}, rx);
    if (write_enable_latch && !(pen && !wpN)) begin
      master.frame(1, 40'h04, rx);
      rd(1);
      pen = dat[7];
      bp  = dat[3:2];
      write_enable_latch = 0;
    end
    waitIdle();
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h8FE9));
    nvIn = nv_t'(3'($urandom));
    pen  = nvIn.pinProtectEnable;
    bp   = {nvIn.blockProtectHi, nvIn.blockProtectLo};
    write_enable_latch  = 0;
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("reset status", st, expSt(0));
    check("nvStore", nvOut, nvIn);
    master.frame(2, 40'h0D00, rx);
    check("read bit3 set", rx, expSt(0));
    master.set_mode(1'b1);
    foreach (addrs[i]) begin
      d = (i % 2) ? 8'h04 : 8'h06;
      wpN = i[1];
      master.frame(1, {32'h0, d | (i > 1 ? 8'h08 : 8'h00)}, rx);
      write_enable_latch = (i % 2) ? 0 : 1;
      rd(0);
    end
    master.set_mode(1'b0);
    wpN = 1'b1;
    master.frame(2, 40'h0600, rx);
    rd(0);
    enCnt = 0;
    master.frame(3, 40'hA50500, rx);
    check("output enable", enCnt, 0);
    master.frame(5, {8'h03, 32'h0}, rx);
    rd(0);
    wrStat(8'($urandom), 0);
    wrStat(8'($urandom) | 8'h80, 1);
    // protect pin pulses low during the data byte and is high again when chip select rises
    master.frame(1, 40'h06, rx);
    write_enable_latch = 1;
    fork
      master.frame(2, 40'h0100, rx);
      begin
        #8000 wpN = 1'b0;
        #2000 wpN = 1'b1;
      end
    join
    waitIdle();
    wpN = 1'b0;
    wrStat(8'($urandom), 1);
    master.frame(1, 40'h04, rx);
    write_enable_latch = 0;
    rd(0);
    wpN = 1'b1;
    for (int b = 0; b < 4; b++) begin
      wrStat({4'h0, b[1:0], 2'h0}, 1);
      foreach (addrs[i]) begin
        master.frame(1, 40'h06, rx);
        write_enable_latch = 1;
        goCnt = 0;
        master.frame(5, {(i % 2) ? 8'h0A : 8'h02, 7'h0, addrs[i][16:0], 8'($urandom)}, rx);
        ok = (b == 0) || (b == 1 && addrs[i] < 32'h18000) || (b == 2 && addrs[i] < 32'h10000);
        if (ok) write_enable_latch = 0;
        waitIdle();
        check("grant", goCnt, ok);
        if (ok) check("grant address", lastAddr, addrs[i][16:0]);
      end
    end
    wrStat(8'h00, 1);
    goCnt = 0;
    master.frame(5, {8'h02, 32'h0}, rx);
    waitIdle();
    check("grant without latch", goCnt, 0);
    finish_test();
  end
endmodule
